// >>> pmc_defines.svh
// Purpose: constants of the power mode controller
// Assumes: 8-bit registers in the low lane of a 32-bit Avalon word
// Notes:   register index times four gives the byte address
`ifndef PMC_DEFINES_SVH
`define PMC_DEFINES_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define PMC_CTRL_IDX 24'hff_fc60
`define PMC_STAT_IDX 24'hff_fc62
`define PMC_CTRL_RST 8'h00

// ----------------------------------------
// control fields
// ----------------------------------------
`define PMC_B_PSM 0
`define PMC_B_IDLE 1
`define PMC_B_HALT 2
`define PMC_B_WAIT 3
`define PMC_B_DMC 4
`define PMC_B_DHC 5

// ----------------------------------------
// status fields
// ----------------------------------------
`define PMC_B_LOW 0
`define PMC_B_MAIN 1
`define PMC_B_PLL 2

// ----------------------------------------
// mode codes on the mode output
// ----------------------------------------
`define PMC_MODE_ACT 2'h0
`define PMC_MODE_PS 2'h1
`define PMC_MODE_IDLE 2'h2
`define PMC_MODE_HALT 2'h3

`endif

// >>> pmc_pkg.sv
// Purpose: types of the power mode controller
// Assumes: nothing
// Notes:   constants live in pmc_defines.svh
package pmc_pkg;
  typedef enum logic [3:0] {
    PMC_ACT = 4'h0,
    PMC_PSAVE = 4'h1,
    PMC_IDLE = 4'h2,
    PMC_HCLK = 4'h3,
    PMC_HPLL = 4'h4,
    PMC_HALT = 4'h5,
    PMC_WOSC = 4'h6,
    PMC_WPLL = 4'h7,
    PMC_EXIT = 4'h8
  } pmc_state_t;
endpackage : pmc_pkg

// >>> pmc_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs come from other clocks or pins
// Notes:   output moves only when stages two and three agree
module pmc_sync #(
  parameter int W = 5
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] agree;

  assign agree = ~(s2_reg ^ s3_reg);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      sync_out <= '0;
    end else begin
      s1_reg <= async_in;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      sync_out <= (s3_reg & agree) | (sync_out & ~agree);
    end
  end
endmodule : pmc_sync

// >>> pmc_top.sv
// Purpose: power mode controller with Avalon-MM register slave
// Assumes: cpu_wait and int_ack come from the cpu on sys_clk
// Notes:   oscillator and pll status arrive asynchronously
`include "pmc_defines.svh"
module pmc_top (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [25:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cpu_wait,
  input wire logic int_ack,
  input wire logic nmi_in,
  input wire logic wake_input_unit_req,
  input wire logic low_osc_ok,
  input wire logic main_osc_ok,
  input wire logic pll_lock,
  input wire logic pll_power_down,
  output logic sys_clk_en,
  output logic slow_clk_sel,
  output logic main_osc_en,
  output logic pll_en,
  output pmc_pkg::pmc_state_t state_out,
  output logic [1:0] power_mode,
  output logic wake_pending
);
  import pmc_pkg::*;

  // ----------------------------------------
  // declarations
  // ----------------------------------------
  pmc_state_t st_reg;
  pmc_state_t st_next;
  logic [4:0] sync_v;
  logic low_ok;
  logic main_ok;
  logic lock_ok;
  logic wake_s;
  logic pll_ok;
  logic [7:0] wd;
  logic wr_ctrl;
  logic wake_hit;
  logic psm_reg;
  logic idle_reg;
  logic halt_reg;
  logic wait_before_lowpower_reg;
  logic dmc_reg;
  logic dhc_reg;
  logic imm_req_reg;
  logic wake_lat_reg;
  logic [7:0] ctrl_rd;
  logic [7:0] stat_rd;

  function automatic logic hit(input logic [25:0] a, input logic [23:0] idx);
    return a[25:2] == idx;
  endfunction : hit

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  pmc_sync #(
    .W(5)
  ) u_sync (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .async_in({nmi_in, wake_input_unit_req, pll_lock, main_osc_ok, low_osc_ok}),
    .sync_out(sync_v)
  );

  assign low_ok = sync_v[0];
  assign main_ok = sync_v[1];
  assign lock_ok = sync_v[2];
  assign wake_s = sync_v[3] | sync_v[4];
  // pll qualifies once enabled and locked, or at once while powered down
  assign pll_ok = pll_power_down | (pll_en & lock_ok);

  // ----------------------------------------
  // avalon slave
  // ----------------------------------------
  // fixed answer: waitrequest drops one edge after the request is seen
  assign wd = avs_writedata[7:0];
  assign wr_ctrl = avs_write && !avs_waitrequest && avs_byteenable[0] && hit(avs_address, `PMC_CTRL_IDX);
  assign ctrl_rd = {2'h0, dhc_reg, dmc_reg, wait_before_lowpower_reg, halt_reg, idle_reg, psm_reg};
  // live clock states, upper bits zero
  assign stat_rd = {5'h00, lock_ok | ~pll_en, main_ok, low_ok};

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      if (hit(avs_address, `PMC_CTRL_IDX)) begin
        avs_readdata <= {24'h00_0000, ctrl_rd};
      end else if (hit(avs_address, `PMC_STAT_IDX)) begin
        avs_readdata <= {24'h00_0000, stat_rd};
      end else begin
        avs_readdata <= 32'h0000_0000;
      end
    end
  end

  // ----------------------------------------
  // wake-up latch
  // ----------------------------------------
  // held until acknowledge; a new event beats the clear
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_lat_reg <= 1'b0;
    end else if (wake_s) begin
      wake_lat_reg <= 1'b1;
    end else if (int_ack) begin
      wake_lat_reg <= 1'b0;
    end
  end

  // only settled low-power states answer a wake
  assign wake_hit = wake_lat_reg && (st_reg == PMC_PSAVE || st_reg == PMC_IDLE || st_reg == PMC_HALT);

  // ----------------------------------------
  // control bits
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      imm_req_reg <= 1'b0;
    end else if (wake_hit || st_reg != PMC_ACT) begin
      imm_req_reg <= 1'b0;
    end else if (imm_req_reg && low_ok) begin
      imm_req_reg <= 1'b0;
    end else if (wr_ctrl) begin
      // request stands until the low oscillator allows it
      imm_req_reg <= wd[`PMC_B_PSM] && !psm_reg && !wait_before_lowpower_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      psm_reg <= 1'b0;
    end else if (st_reg == PMC_ACT && imm_req_reg && low_ok) begin
      // an immediate request sets it only when power save is reached
      psm_reg <= 1'b1;
    end else if (st_reg == PMC_EXIT && main_ok && pll_ok) begin
      psm_reg <= 1'b0;
    end else if (wake_hit) begin
      psm_reg <= 1'b0;
    end else if (wr_ctrl && st_reg == PMC_ACT) begin
      // armed request reads back at once
      if (wd[`PMC_B_PSM] && wait_before_lowpower_reg) begin
        psm_reg <= 1'b1;
      end else if (!wd[`PMC_B_PSM]) begin
        psm_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      idle_reg <= 1'b0;
    end else if (wake_hit) begin
      idle_reg <= 1'b0;
    end else if (wr_ctrl && st_reg == PMC_ACT) begin
      idle_reg <= wd[`PMC_B_IDLE];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      halt_reg <= 1'b0;
    end else if (st_reg == PMC_WOSC && main_ok) begin
      halt_reg <= 1'b0;
    end else if (wr_ctrl && st_reg == PMC_ACT) begin
      halt_reg <= wd[`PMC_B_HALT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wait_before_lowpower_reg <= 1'b0;
    end else if (wr_ctrl) begin
      wait_before_lowpower_reg <= wd[`PMC_B_WAIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dmc_reg <= 1'b0;
    end else if (wake_hit) begin
      dmc_reg <= 1'b0;
    end else if (wr_ctrl) begin
      dmc_reg <= wd[`PMC_B_DMC];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      dhc_reg <= 1'b0;
    end else if (st_reg == PMC_WOSC && main_ok) begin
      // pll disable cleared after oscillator settles
      dhc_reg <= 1'b0;
    end else if (wr_ctrl) begin
      dhc_reg <= wd[`PMC_B_DHC];
    end
  end

  // ----------------------------------------
  // mode sequencer
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    unique case (st_reg)
      PMC_ACT: begin
        // no descent without the low oscillator
        if (imm_req_reg && low_ok) begin
          st_next = PMC_PSAVE;
        end else if (cpu_wait && wait_before_lowpower_reg && low_ok) begin
          if (halt_reg) begin
            st_next = PMC_HCLK;
          end else if (idle_reg) begin
            st_next = PMC_IDLE;
          end else if (psm_reg) begin
            st_next = PMC_PSAVE;
          end
        end
      end
      PMC_PSAVE: begin
        if (wake_hit) begin
          st_next = PMC_WOSC;
        end else if (wr_ctrl && !wd[`PMC_B_PSM]) begin
          st_next = PMC_EXIT;
        end
      end
      PMC_IDLE: begin
        if (wake_hit) begin
          st_next = PMC_WOSC;
        end
      end
      PMC_HCLK: st_next = PMC_HPLL;
      PMC_HPLL: st_next = PMC_HALT;
      PMC_HALT: begin
        if (wake_hit) begin
          st_next = PMC_WOSC;
        end
      end
      // oscillator stable, then pll stable, then active
      PMC_WOSC: begin
        if (main_ok) begin
          st_next = PMC_WPLL;
        end
      end
      PMC_WPLL: begin
        if (pll_ok) begin
          st_next = PMC_ACT;
        end
      end
      PMC_EXIT: begin
        // return to active waits for stable clocks
        if (main_ok && pll_ok) begin
          st_next = PMC_ACT;
        end
      end
      default: st_next = PMC_ACT;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg <= PMC_ACT;
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // clock controls
  // ----------------------------------------
  // outputs trail the state by one edge, keeping the halt order intact
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sys_clk_en <= 1'b1;
      slow_clk_sel <= 1'b0;
      main_osc_en <= 1'b1;
      pll_en <= 1'b0;
      power_mode <= `PMC_MODE_ACT;
      state_out <= PMC_ACT;
      wake_pending <= 1'b0;
    end else begin
      state_out <= st_reg;
      wake_pending <= wake_lat_reg;
      // clocks restored by hardware, execution left to the handler
      sys_clk_en <= !(st_reg inside {PMC_IDLE, PMC_HCLK, PMC_HPLL, PMC_HALT});
      slow_clk_sel <= st_reg inside {PMC_PSAVE, PMC_IDLE, PMC_WOSC, PMC_WPLL};
      // disable bits act only in power save and idle, the pll disable bit also in WOSC
      main_osc_en <= (st_reg inside {PMC_PSAVE, PMC_IDLE}) ? !dmc_reg : (st_reg != PMC_HALT);
      // pll follows disable bit and power-down in power save
      if (pll_power_down) begin
        pll_en <= 1'b0;
      end else if (st_reg inside {PMC_PSAVE, PMC_IDLE, PMC_WOSC}) begin
        pll_en <= !dhc_reg;
      end else begin
        pll_en <= !(st_reg inside {PMC_HPLL, PMC_HALT});
      end
      if (st_reg inside {PMC_HCLK, PMC_HPLL, PMC_HALT}) begin
        power_mode <= `PMC_MODE_HALT;
      end else if (st_reg == PMC_IDLE) begin
        power_mode <= `PMC_MODE_IDLE;
      end else if (st_reg == PMC_ACT) begin
        power_mode <= `PMC_MODE_ACT;
      end else begin
        power_mode <= `PMC_MODE_PS;
      end
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_halt_go;
    st_reg == PMC_ACT && !imm_req_reg && cpu_wait && wait_before_lowpower_reg && halt_reg && low_ok;
  endsequence

  sequence s_halt_walk;
    st_reg == PMC_HCLK ##1 st_reg == PMC_HPLL ##1 st_reg == PMC_HALT;
  endsequence

  property p_imm_entry;
    st_reg == PMC_ACT && imm_req_reg && low_ok |=> st_reg == PMC_PSAVE && psm_reg;
  endproperty
  a_imm_entry: assert property (p_imm_entry) else $error("immediate power save missed");

  property p_psm_late;
    imm_req_reg |-> !psm_reg;
  endproperty
  a_psm_late: assert property (p_psm_late) else $error("psm set before entry");

  property p_psm_armed;
    wr_ctrl && st_reg == PMC_ACT && wait_before_lowpower_reg && wd[`PMC_B_PSM] && !wake_hit |=> psm_reg;
  endproperty
  a_psm_armed: assert property (p_psm_armed) else $error("armed psm not readable");

  property p_low_guard;
    st_reg == PMC_ACT && !low_ok |=> st_reg == PMC_ACT;
  endproperty
  a_low_guard: assert property (p_low_guard) else $error("descent without low oscillator");

  property p_up_guard;
    st_reg != PMC_ACT ##1 st_reg == PMC_ACT |-> $past(main_ok) && $past(pll_ok);
  endproperty
  a_up_guard: assert property (p_up_guard) else $error("active without stable clocks");

  property p_halt_order;
    s_halt_go |=> s_halt_walk ##1 !pll_en && !main_osc_en && !sys_clk_en;
  endproperty
  a_halt_order: assert property (p_halt_order) else $error("halt entry order wrong");

  property p_clk_first;
    st_reg == PMC_HPLL |-> !sys_clk_en && main_osc_en;
  endproperty
  a_clk_first: assert property (p_clk_first) else $error("system clock not stopped first");

  property p_halt_hold;
    st_reg == PMC_WOSC && halt_reg && !main_ok |=> halt_reg;
  endproperty
  a_halt_hold: assert property (p_halt_hold) else $error("halt cleared before oscillator");

  property p_osc_active;
    st_reg == PMC_ACT ##1 st_reg == PMC_ACT |=> main_osc_en;
  endproperty
  a_osc_active: assert property (p_osc_active) else $error("oscillator off in active");

  property p_wake_hold;
    wake_lat_reg && !int_ack |=> wake_lat_reg;
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake latch lost");

  property p_wake_order;
    st_reg == PMC_WOSC && !main_ok |-> !dmc_reg ##1 st_reg != PMC_WPLL;
  endproperty
  a_wake_order: assert property (p_wake_order) else $error("wake order broken");

endmodule : pmc_top

// >>> pmc_clk_model.sv
// Purpose: oscillator and pll stand-in facing the power mode controller
// Assumes: enables come straight from the controller on sys_clk
// Notes:   stability levels need a settle time, so waits are visible
module pmc_clk_model #(
  parameter int MAIN_DLY = 20,
  parameter int PLL_DLY = 12
) (
  input wire logic sys_clk,
  input wire logic low_good,
  input wire logic main_osc_en,
  input wire logic pll_en,
  output logic low_osc_ok,
  output logic main_osc_ok,
  output logic pll_lock
);
  timeunit 1ns;
  timeprecision 1ps;
  int main_cnt = 0;
  int pll_cnt = 0;

  // ----------------------------------------
  // settling counters
  // ----------------------------------------
  // stability drops at once when disabled, never lingers
  initial begin
    main_osc_ok = 1'b0;
    pll_lock = 1'b0;
  end
  assign low_osc_ok = low_good;
  always @(posedge sys_clk) begin
    if (!main_osc_en) begin
      main_cnt <= 0;
      main_osc_ok <= 1'b0;
    end else if (main_cnt >= MAIN_DLY) begin
      main_osc_ok <= 1'b1;
    end else begin
      main_cnt <= main_cnt + 1;
    end
  end
  // pll lock also needs the reference oscillator running
  always @(posedge sys_clk) begin
    if (!pll_en || !main_osc_ok) begin
      pll_cnt <= 0;
      pll_lock <= 1'b0;
    end else if (pll_cnt >= PLL_DLY) begin
      pll_lock <= 1'b1;
    end else begin
      pll_cnt <= pll_cnt + 1;
    end
  end
endmodule : pmc_clk_model

// >>> pmc_top_tb.sv
// Purpose: self-checking bench of the power mode controller
// Assumes: registers at byte addresses 0x3fff180 and 0x3fff188
// Notes:   wake sources are held four cycles, or until the oscillator is enabled, to pass the sync filter
module pmc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [25:0] CTRL = 26'h3ff_f180;
  localparam logic [25:0] STAT = 26'h3ff_f188;
  logic sys_clk = 1'b0, sys_rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
  logic [25:0] avs_address = 26'h000_0000;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic [3:0] avs_byteenable = 4'h1;
  logic avs_waitrequest, cpu_wait = 1'b0, int_ack = 1'b0, nmi_in = 1'b0, wake_input_unit_req = 1'b0;
  logic low_good = 1'b0, pll_power_down = 1'b0, low_osc_ok, main_osc_ok, pll_lock;
  logic sys_clk_en, slow_clk_sel, main_osc_en, pll_en, wake_pending;
  logic [1:0] power_mode;
  pmc_pkg::pmc_state_t state_out;
  logic [7:0] rd;
  int bad_count = 0, comparisons = 0, ta, tb, tc;

  pmc_top u_pmc_top (.sys_clk(sys_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .cpu_wait(cpu_wait), .int_ack(int_ack), .nmi_in(nmi_in), .wake_input_unit_req(wake_input_unit_req),
    .low_osc_ok(low_osc_ok), .main_osc_ok(main_osc_ok), .pll_lock(pll_lock),
    .pll_power_down(pll_power_down), .sys_clk_en(sys_clk_en), .slow_clk_sel(slow_clk_sel),
    .main_osc_en(main_osc_en), .pll_en(pll_en), .state_out(state_out), .power_mode(power_mode),
    .wake_pending(wake_pending));
  pmc_clk_model u_pmc_clk_model (.sys_clk(sys_clk), .low_good(low_good), .main_osc_en(main_osc_en),
    .pll_en(pll_en), .low_osc_ok(low_osc_ok), .main_osc_ok(main_osc_ok), .pll_lock(pll_lock));

  initial begin
    forever #4 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // checking and bus tasks
  // ----------------------------------------
  task complete_run;
    $display("mismatches %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run
  task chk_reg(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_reg
  task chk_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected level at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_pin
  // request held until the edge that samples waitrequest low
  task av_access(input logic wr, input logic [25:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= wr;
    avs_read <= ~wr;
    // no local limit: the watchdog ends a hung access
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : av_access
  task av_write(input logic [25:0] a, input logic [7:0] d);
    av_access(1'b1, a, d);
  endtask : av_write
  task av_read(input logic [25:0] a);
    av_access(1'b0, a, 8'h00);
  endtask : av_read
  task pulse_wait;
    cpu_wait <= 1'b1;
    @(posedge sys_clk);
    cpu_wait <= 1'b0;
  endtask : pulse_wait
  task ack_wake;
    int_ack <= 1'b1;
    @(posedge sys_clk);
    int_ack <= 1'b0;
    repeat (2) @(posedge sys_clk);
  endtask : ack_wake
  task wait_mode(input logic [1:0] m);
    for (int i = 0; i < 300 && power_mode !== m; i++) @(posedge sys_clk);
    chk_reg({6'h00, power_mode}, {6'h00, m});
  endtask : wait_mode
  // first cycles of oscillator enable, pll enable and active mode
  task trace_wake(input logic use_nmi);
    ta = -1;
    tb = -1;
    tc = -1;
    if (use_nmi) nmi_in <= 1'b1;
    else wake_input_unit_req <= 1'b1;
    for (int i = 0; i < 200; i++) begin
      @(posedge sys_clk);
      if (i == 3) begin
        nmi_in <= 1'b0;
        wake_input_unit_req <= 1'b0;
      end
      if (main_osc_en === 1'b1 && ta < 0) ta = i;
      if (pll_en === 1'b1 && tb < 0) tb = i;
      if (power_mode === 2'h0 && tc < 0) tc = i;
    end
  endtask : trace_wake

  // ----------------------------------------
  // test sequence
  // ----------------------------------------
  initial begin
    repeat (5) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (30) @(posedge sys_clk);
    av_read(CTRL);
    chk_reg(rd, 8'h00);
    av_read(STAT);
    chk_reg(rd, 8'h06);
    av_read(26'h000_0010);
    chk_reg(rd, 8'h00);
    av_write(CTRL, 8'h01);
    repeat (10) @(posedge sys_clk);
    av_read(CTRL);
    chk_reg(rd, 8'h00);
    chk_reg({6'h00, power_mode}, 8'h00);
    low_good <= 1'b1;
    wait_mode(2'h1);
    av_read(CTRL);
    chk_reg(rd, 8'h01);
    chk_pin(slow_clk_sel, 1'b1);
    chk_pin(pll_en, 1'b1);
    // power-down overrides the clear pll disable bit
    pll_power_down <= 1'b1;
    repeat (3) @(posedge sys_clk);
    chk_pin(pll_en, 1'b0);
    pll_power_down <= 1'b0;
    av_write(CTRL, 8'h00);
    wait_mode(2'h0);
    av_read(CTRL);
    chk_reg(rd, 8'h00);
    // wait bit set first, then the request shows before WAIT
    av_write(CTRL, 8'h38);
    av_write(CTRL, 8'h39);
    av_read(CTRL);
    chk_reg(rd, 8'h39);
    chk_reg({6'h00, power_mode}, 8'h00);
    chk_pin(main_osc_en, 1'b1);
    pulse_wait();
    wait_mode(2'h1);
    repeat (30) @(posedge sys_clk);
    chk_pin(main_osc_en, 1'b0);
    chk_pin(pll_en, 1'b0);
    av_read(STAT);
    chk_reg(rd, 8'h05);
    trace_wake(1'b1);
    chk_pin(ta >= 0 && ta < tb && tb < tc, 1'b1);
    av_read(CTRL);
    chk_reg(rd, 8'h08);
    chk_pin(wake_pending, 1'b1);
    ack_wake();
    chk_pin(wake_pending, 1'b0);
    // halt entry order, then wake from halt
    av_write(CTRL, 8'h3c);
    repeat (20) @(posedge sys_clk);
    ta = -1;
    tb = -1;
    tc = -1;
    pulse_wait();
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (sys_clk_en === 1'b0 && ta < 0) ta = i;
      if (pll_en === 1'b0 && tb < 0) tb = i;
      if (main_osc_en === 1'b0 && tc < 0) tc = i;
    end
    chk_pin(ta >= 0 && ta < tb && tb < tc, 1'b1);
    chk_reg({6'h00, power_mode}, 8'h03);
    chk_reg({4'h0, state_out}, {4'h0, pmc_pkg::PMC_HALT});
    wake_input_unit_req <= 1'b1;
    for (int i = 0; i < 100 && main_osc_en !== 1'b1; i++) @(posedge sys_clk);
    wake_input_unit_req <= 1'b0;
    av_read(CTRL);
    chk_reg(rd, 8'h2c);
    wait_mode(2'h0);
    av_read(CTRL);
    chk_reg(rd, 8'h08);
    ack_wake();
    // idle, blocked first by low oscillator
    low_good <= 1'b0;
    repeat (8) @(posedge sys_clk);
    av_write(CTRL, 8'h3a);
    pulse_wait();
    repeat (10) @(posedge sys_clk);
    chk_reg({6'h00, power_mode}, 8'h00);
    low_good <= 1'b1;
    repeat (8) @(posedge sys_clk);
    pulse_wait();
    wait_mode(2'h2);
    trace_wake(1'b0);
    chk_pin(tc >= 0 && tb < tc, 1'b1);
    av_read(CTRL);
    chk_reg(rd, 8'h08);
    ack_wake();
    complete_run();
  end

  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
endmodule : pmc_top_tb
